// file: rtl/sbs_defs.vh
// Constants shared by the burst SRAM control front end.
`ifndef SBS_DEFS_VH
`define SBS_DEFS_VH
`define SBS_AW 2
`define SBS_DW 8
`define SBS_ORDER_LINEAR 1'b0
`define SBS_ORDER_INTERLEAVED 1'b1
`endif

// file: rtl/sbs_burst_seq.v
// Burst address sequencer with linear and interleaved order.
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defs.vh"
module sbs_burst_seq (
   input wire sys_clk,
   input wire rst_n,
   input wire load,
   input wire advance,
   input wire order_mode,
   input wire [`SBS_AW-1:0] start_low,
   output wire [`SBS_AW-1:0] burst_low
);
   reg [`SBS_AW-1:0] base_q;
   reg [`SBS_AW-1:0] count_q;
   // Load takes the start bits; advance steps the count; otherwise the count holds.
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         base_q <= {`SBS_AW{1'b0}};
         count_q <= {`SBS_AW{1'b0}};
      end
      else if (load)
      begin
         base_q <= start_low;
         count_q <= {`SBS_AW{1'b0}};
      end
      else if (advance)
      begin
         count_q <= count_q + 2'h1;
      end
   end
   // Interleaved order XORs the count into the start; linear order adds it.
   assign burst_low = (order_mode == `SBS_ORDER_INTERLEAVED) ? (base_q ^ count_q)
                                                               : (base_q + count_q);
endmodule // sbs_burst_seq
`default_nettype wire

// file: rtl/sbs_ctrl.v
// Control front end of a synchronous pipelined burst SRAM.
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defs.vh"
module sbs_ctrl (
   input wire sys_clk,
   input wire rst_n,
   input wire select_low_a,
   input wire select_high_b,
   input wire select_low_c,
   input wire clock_qualify_n,
   input wire sleep_request,
   input wire burst_order,
   input wire write_n,
   input wire advance_load,
   input wire [`SBS_AW-1:0] addr_low,
   input wire [`SBS_DW-1:0] data_in,
   output wire [`SBS_AW-1:0] access_low,
   output reg write_strobe,
   output reg [`SBS_DW-1:0] write_data,
   output reg data_oe_n,
   output reg sleeping,
   output reg selected
);
   // Pipeline timing: an access is taken on a qualified edge while selected with load low.
   // The state register shows it from that same edge, and the write strobe or the driven data pins
   // follow one more qualified edge after that. A stall edge adds one cycle to every step.
   // Sleep is entered only from idle while deselected, and left to idle with the pins released.

   // State codes of the access sequencer, plain binary.
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_READ = 2'h1;
   localparam [1:0] ST_WRITE = 2'h2;
   localparam [1:0] ST_SLEEP = 2'h3;

   // Sequencer state and the write data held for the data phase.
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [`SBS_DW-1:0] wdata_q;
   // Decoded controls of the current cycle.
   wire chip_sel;
   wire qual;
   wire in_access;
   wire start;
   wire cont;
   wire sleep_ok;
   wire sleep_zone;
   // Next values of the registered outputs.
   wire strobe_d;
   wire oe_n_d;
   wire selected_d;
   wire sleeping_d;
   wire [`SBS_DW-1:0] wr_data_d;

   // Decode the three enables into one select; every other mix deselects.
   assign chip_sel = ~select_low_a & select_high_b & ~select_low_c;
   // A high qualify pin turns the edge into a stall.
   assign qual = ~clock_qualify_n;
   // The sequencer is inside an access once a read or a write has been taken.
   assign in_access = (state_q == ST_READ) | (state_q == ST_WRITE);
   // A new access starts on a selected, qualified load cycle.
   assign start = qual & chip_sel & ~advance_load;
   // Continue steps the burst only inside an access; single accesses never need it.
   assign cont = qual & advance_load & in_access;
   // Sleep is honoured only from idle with the device deselected.
   assign sleep_ok = sleep_request & ~chip_sel & (state_q == ST_IDLE);
   // Edges that enter or leave sleep force the pins released and the strobe low.
   assign sleep_zone = (state_d == ST_SLEEP) | (state_q == ST_SLEEP);

   // Burst address sequencer; a stall neither loads nor steps it.
   sbs_burst_seq u_seq (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .load(start),
      .advance(cont),
      .order_mode(burst_order),
      .start_low(addr_low),
      .burst_low(access_low)
   );

   // Next state; a stall holds a read or write state, so the pending access resumes afterwards.
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (sleep_ok)
               state_d = ST_SLEEP;
            else if (!qual)
               state_d = state_q;
            else if (start)
               state_d = write_n ? ST_READ : ST_WRITE;
         end
         ST_READ:
         begin
            if (!qual)
               state_d = state_q;
            else if (start)
               state_d = write_n ? ST_READ : ST_WRITE;
            else if (!advance_load)
               state_d = ST_IDLE;
         end
         ST_WRITE:
         begin
            if (!qual)
               state_d = state_q;
            else if (start)
               state_d = write_n ? ST_READ : ST_WRITE;
            else if (!advance_load)
               state_d = ST_IDLE;
         end
         ST_SLEEP:
         begin
            if (!sleep_request)
               state_d = ST_IDLE;
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // State register.
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   // Capture write data only on qualified edges, so a stall keeps the pending data.
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         wdata_q <= {`SBS_DW{1'b0}};
      else if (qual)
         wdata_q <= data_in;
   end

   // Write strobe one qualified edge after the write was taken; low in every stall.
   assign strobe_d = qual & ~sleep_zone & (state_q == ST_WRITE);
   // Data pins driven one qualified edge after a read was taken; released around sleep.
   assign oe_n_d = sleep_zone ? 1'b1 : (qual ? (state_q != ST_READ) : data_oe_n);
   // Select shows the last qualified decode and is cleared around sleep.
   assign selected_d = sleep_zone ? 1'b0 : (qual ? chip_sel : selected);
   // Write data moves on qualified edges outside sleep and holds otherwise.
   assign wr_data_d = (qual & ~sleep_zone) ? wdata_q : write_data;
   // Sleep flag follows the next state, so it rises on the entry edge.
   assign sleeping_d = (state_d == ST_SLEEP);

   // Write strobe register.
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         write_strobe <= 1'b0;
      end
      else
      begin
         write_strobe <= strobe_d;
      end
   end

   // Write data register.
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         write_data <= {`SBS_DW{1'b0}};
      end
      else
      begin
         write_data <= wr_data_d;
      end
   end

   // Data pin enable register, high while the pins are released.
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         data_oe_n <= 1'b1;
      end
      else
      begin
         data_oe_n <= oe_n_d;
      end
   end

   // Sleep flag register.
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sleeping <= 1'b0;
      end
      else
      begin
         sleeping <= sleeping_d;
      end
   end

   // Select register.
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         selected <= 1'b0;
      end
      else
      begin
         selected <= selected_d;
      end
   end
endmodule // sbs_ctrl
`default_nettype wire

// file: verif/sbs_ctrl_chk.sv
// Checker that watches the control front end at its ports.
`timescale 1ns/1ps
`default_nettype none
module sbs_ctrl_chk (
   input wire sys_clk,
   input wire rst_n,
   input wire select_low_a,
   input wire select_high_b,
   input wire select_low_c,
   input wire clock_qualify_n,
   input wire write_n,
   input wire advance_load,
   input wire [1:0] access_low,
   input wire write_strobe,
   input wire [7:0] write_data,
   input wire data_oe_n,
   input wire sleeping,
   input wire selected
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // A write start taken on a qualified edge while selected.
   sequence s_wr;
      !sleeping && !clock_qualify_n && !select_low_a && select_high_b && !select_low_c && !advance_load && !write_n;
   endsequence
   // One stalled edge followed by a qualified one.
   sequence s_stall_then_go;
      clock_qualify_n ##1 !clock_qualify_n;
   endsequence
   a_sel_decode: assert property (!$past(clock_qualify_n) |->
      selected == $past(!select_low_a && select_high_b && !select_low_c)) else $error("Select decode wrong.");
   a_stall_no_write: assert property (clock_qualify_n |=> !write_strobe) else $error("Write in stall.");
   a_write_due: assert property (s_wr ##1 !clock_qualify_n |=> write_strobe) else $error("No strobe.");
   a_write_resume: assert property (s_wr ##1 s_stall_then_go |=> write_strobe)
      else $error("No strobe after stall.");
   a_stall_hold: assert property (clock_qualify_n |=> $stable(selected) && $stable(data_oe_n) &&
      $stable(access_low) && $stable(write_data)) else $error("Stall changed state.");
   a_wake_hiz: assert property ($fell(sleeping) |-> data_oe_n [*2]) else $error("Driven on wake.");
endmodule // sbs_ctrl_chk
bind sbs_ctrl sbs_ctrl_chk chk (.sys_clk, .rst_n, .select_low_a, .select_high_b, .select_low_c,
   .clock_qualify_n, .write_n, .advance_load, .access_low, .write_strobe, .write_data, .data_oe_n,
   .sleeping, .selected);
`default_nettype wire

// file: verif/sbs_ctl_model.sv
// Model of the memory controller that drives the control pins.
`timescale 1ns/1ps
`default_nettype none
module sbs_ctl_model (
   input wire logic sys_clk,
   output logic [2:0] sel,
   output logic q_n,
   output logic zz,
   output logic wr_n,
   output logic adv,
   output logic [1:0] ad,
   output logic [7:0] din
);
   // Deselected and stalled from time zero.
   initial {sel, q_n, zz, wr_n, adv, ad, din} = {3'h0, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 8'h00};
   // One bus cycle, single access or continuation alike.
   task cyc(input logic [2:0] s, input logic q, input logic w, input logic l, input logic [1:0] a,
      input logic [7:0] d);
      @(posedge sys_clk);
      #2 {sel, q_n, wr_n, adv, ad, din} = {s, q, w, l, a, d};
   endtask
   // Sleep changes only after a deselect cycle.
   task nap(input logic z);
      cyc(3'h0, 1'b0, 1'b1, 1'b0, 2'h0, 8'h00);
      @(posedge sys_clk);
      #2 zz = z;
   endtask
endmodule // sbs_ctl_model
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the control front end.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin tests_run++; if ((a) !== (b)) begin errors++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module testbench;
   logic sys_clk = 0, rst_n = 0, mode = 0, zz, q_n, wr_n, adv, ws, oe_n, slp, sd;
   logic [2:0] sel;
   logic [1:0] ad, al;
   logic [7:0] din, wd;
   int errors = 0, tests_run = 0, cyc_n = 0;
   sbs_ctl_model p (.sys_clk, .sel, .q_n, .zz, .wr_n, .adv, .ad, .din);
   sbs_ctrl uut (.sys_clk, .rst_n, .select_low_a(sel[2]), .select_high_b(sel[1]), .select_low_c(sel[0]),
      .clock_qualify_n(q_n), .sleep_request(zz), .burst_order(mode), .write_n(wr_n), .advance_load(adv),
      .addr_low(ad), .data_in(din), .access_low(al), .write_strobe(ws), .write_data(wd), .data_oe_n(oe_n),
      .sleeping(slp), .selected(sd));
   // Clock and cycle ceiling.
   initial forever #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (++cyc_n > 2000) begin errors++; tally_and_finish(); end
   task tally_and_finish;
      if (errors == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Every enable combination; only one of them selects.
   task t_select;
      for (int s = 0; s < 8; s++)
      begin
         p.cyc(3'(s), 1'b0, 1'b1, 1'b0, 2'h0, 8'h00);
         @(posedge sys_clk) #1;
         `CHK(sd, 1'(s == 2))
      end
   endtask
   // Back-to-back writes, then a write with a stall before its data edge.
   task t_write;
      for (int st = 0; st < 2; st++)
      begin
         p.cyc(3'h2, 1'b0, 1'b0, 1'b0, 2'h1, 8'h5a);
         p.cyc(3'h2, 1'(st), 1'b0, 1'b0, 2'h1, 8'h3c);
         p.cyc(3'h0, 1'b0, 1'b1, 1'b0, 2'h1, 8'h5a);
         `CHK(ws, 1'(st == 0))
         for (int i = 0; i < 6 && ws !== 1'b1; i++) @(posedge sys_clk) #1;
         `CHK(ws, 1'b1)
         `CHK(wd, 8'h5a)
         @(posedge sys_clk) #1;
         `CHK(ws, 1'(st == 0))
         `CHK(wd, st ? 8'h5a : 8'h3c)
         repeat (3) @(posedge sys_clk);
      end
   endtask
   // Read from 1 then continue across a stall; next address follows the strap.
   task t_burst(input logic m);
      p.cyc(3'h0, 1'b0, 1'b1, 1'b0, 2'h0, 8'h00);
      mode = m;
      p.cyc(3'h2, 1'b0, 1'b1, 1'b0, 2'h1, 8'h00);
      p.cyc(3'h2, 1'b1, 1'b1, 1'b1, 2'h1, 8'h00);
      p.cyc(3'h2, 1'b0, 1'b1, 1'b1, 2'h1, 8'h00);
      p.cyc(3'h0, 1'b0, 1'b1, 1'b0, 2'h0, 8'h00);
      `CHK(al, m ? 2'h0 : 2'h2)
   endtask
   // Enter sleep while deselected, then wake with the data pins released.
   task t_sleep;
      p.nap(1'b1);
      for (int i = 0; i < 8 && slp !== 1'b1; i++) @(posedge sys_clk) #1;
      `CHK(slp, 1'b1)
      p.nap(1'b0);
      for (int i = 0; i < 8 && slp !== 1'b0; i++) @(posedge sys_clk) #1;
      `CHK(oe_n, 1'b1)
      p.cyc(3'h2, 1'b0, 1'b1, 1'b0, 2'h0, 8'h00);
      p.cyc(3'h0, 1'b0, 1'b1, 1'b0, 2'h0, 8'h00);
      @(posedge sys_clk) #1;
      `CHK(oe_n, 1'b0)
   endtask
   // Reset for four cycles, then each scenario in turn.
   initial
   begin
      repeat (4) @(posedge sys_clk);
      #2 rst_n = 1;
      t_select();
      t_write();
      t_burst(1'b0);
      t_burst(1'b1);
      t_sleep();
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
